// File: rtl/sram_host_params.svh
/*
 * Timing counts and field widths for the static memory host controller.
 * Assumes a 10 MHz ref_clk (100 ns period); included by the controller only.
 */
`ifndef SRAM_HOST_PARAMS_SVH
`define SRAM_HOST_PARAMS_SVH
`define CLK_PERIOD_NS 100
`define ADDR_W 13
`define DATA_W 8
`define READ_CYCLE_NS 15
`define WRITE_PULSE_NS 10
`define WRITE_TO_FLOAT_DELAY_NS 8
`define DATA_OVERLAP_NS 8
`define DESELECT_TO_RETENTION_TIME_NS 0
`define RETENTION_RECOVERY_TIME_NS `READ_CYCLE_NS
`define CEIL_CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define READ_CYC `CEIL_CYC(`READ_CYCLE_NS)
`define FLOAT_CYC `CEIL_CYC(`WRITE_TO_FLOAT_DELAY_NS)
`define OVERLAP_CYC `CEIL_CYC(`DATA_OVERLAP_NS)
`define RECOVERY_CYC `CEIL_CYC(`RETENTION_RECOVERY_TIME_NS)
`define CNT_W 4
`endif

// File: rtl/sram_host_pkg.sv
/*
 * Types for the static memory host controller.
 * Assumes nothing beyond the shared parameter header.
 */
package sram_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WR_FLOAT = 3'b010,
        ST_WR_DATA = 3'b011,
        ST_WR_END = 3'b100,
        ST_RETAIN = 3'b101,
        ST_RECOVER = 3'b110
    } host_state_t;
endpackage

// File: rtl/sram_host.sv
/*
 * Host controller that drives an asynchronous 8K x 8 static memory through its pins.
 * Assumes the memory sits on the board pins; the bidirectional data bus is split into
 * input, output and output enable, and a testbench or pad resolves the wire.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sram_host_params.svh"

// Overview of operation
// - The write strobe stays high for the whole of every read.
// - For a select-paced read the address is valid no later than the selects go active.
// - The address changes only while the strobe is high or the memory is deselected.
// - A strobe-paced write with drive enable low lasts longer than float delay plus overlap.
// - Write data is not driven while the memory may still be driving the shared pins.
// - During low-supply retention the memory is held deselected on both selects.
// - Deselect happens no later than the start of supply reduction.
// - After supply returns, the memory stays deselected one read cycle before any access.
module sram_host
    import sram_host_pkg::*;
#(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic retain_req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic retain_safe,
    output logic [ADDR_W-1:0] mem_addr,
    output logic select_n,
    output logic select_active_high,
    output logic drive_en_n,
    output logic write_n,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe
);
    host_state_t state_reg, state_next;
    logic [`CNT_W-1:0] cnt_reg, cnt_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] dq_meta_reg, dq_sync_reg;
    logic retain_meta_reg, retain_sync_reg;
    logic [ADDR_W-1:0] addr_next;
    logic sel_next, we_n_next, oe_n_next, dq_oe_next, ready_next, rsp_next, safe_next;
    logic cnt_done;
    logic req_take, read_done;

    localparam logic [`CNT_W-1:0] READ_CNT = `CNT_W'(`READ_CYC + 2);
    localparam logic [`CNT_W-1:0] FLOAT_CNT = `CNT_W'(`FLOAT_CYC);
    localparam logic [`CNT_W-1:0] OVERLAP_CNT = `CNT_W'(`OVERLAP_CYC);
    localparam logic [`CNT_W-1:0] RECOVER_CNT = `CNT_W'(`RECOVERY_CYC);

    assign cnt_done = (cnt_reg == '0);
    // Retention entry outranks a request in the same idle cycle; the request then waits.
    assign req_take = req_valid && req_ready && !retain_sync_reg;
    assign read_done = (state_reg == ST_READ) && cnt_done;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_done ? cnt_reg : cnt_reg - `CNT_W'(1);
        addr_next = mem_addr;
        sel_next = 1'b0;
        we_n_next = 1'b1;
        oe_n_next = 1'b1;
        dq_oe_next = 1'b0;
        ready_next = 1'b0;
        rsp_next = 1'b0;
        safe_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                ready_next = 1'b1;
                if (retain_sync_reg) begin
                    state_next = ST_RETAIN;
                    ready_next = 1'b0;
                    safe_next = 1'b1;
                end else if (req_take) begin
                    addr_next = req_addr;
                    ready_next = 1'b0;
                    if (req_write) begin
                        state_next = ST_WR_FLOAT;
                        cnt_next = FLOAT_CNT;
                        we_n_next = 1'b0;
                    end else begin
                        state_next = ST_READ;
                        cnt_next = READ_CNT;
                    end
                end
            end
            ST_READ: begin
                sel_next = 1'b1;
                oe_n_next = 1'b0;
                we_n_next = 1'b1;
                if (cnt_done) begin
                    state_next = ST_IDLE;
                    rsp_next = 1'b1;
                    sel_next = 1'b0;
                    oe_n_next = 1'b1;
                    ready_next = 1'b1;
                end
            end
            ST_WR_FLOAT: begin
                sel_next = 1'b1;
                we_n_next = 1'b0;
                if (cnt_done) begin
                    state_next = ST_WR_DATA;
                    cnt_next = OVERLAP_CNT;
                    dq_oe_next = 1'b1;
                end
            end
            ST_WR_DATA: begin
                sel_next = 1'b1;
                we_n_next = 1'b0;
                dq_oe_next = 1'b1;
                if (cnt_done) begin
                    state_next = ST_WR_END;
                    we_n_next = 1'b1;
                end
            end
            ST_WR_END: begin
                // Data held one cycle past the strobe for hold margin.
                dq_oe_next = 1'b0;
                state_next = ST_IDLE;
                ready_next = 1'b1;
            end
            ST_RETAIN: begin
                safe_next = 1'b1;
                if (!retain_sync_reg) begin
                    state_next = ST_RECOVER;
                    cnt_next = RECOVER_CNT;
                    safe_next = 1'b0;
                end
            end
            ST_RECOVER: begin
                if (cnt_done) begin
                    state_next = ST_IDLE;
                    ready_next = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            retain_meta_reg <= 1'b0;
            retain_sync_reg <= 1'b0;
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
        end else begin
            retain_meta_reg <= retain_req;
            retain_sync_reg <= retain_meta_reg;
            dq_meta_reg <= dq_in;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            mem_addr <= '0;
            select_n <= 1'b1;
            select_active_high <= 1'b0;
            drive_en_n <= 1'b1;
            write_n <= 1'b1;
            dq_oe <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            retain_safe <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            mem_addr <= addr_next;
            select_n <= ~sel_next;
            select_active_high <= sel_next;
            drive_en_n <= oe_n_next;
            write_n <= we_n_next;
            dq_oe <= dq_oe_next;
            req_ready <= ready_next;
            rsp_valid <= rsp_next;
            retain_safe <= safe_next;
        end
    end

    // Data registers carry no control meaning, so they skip the reset tree.
    always_ff @(posedge ref_clk) begin
        if (state_reg == ST_IDLE && req_take && req_write) begin
            wdata_reg <= req_wdata;
        end
        // The synchroniser holds pins sampled while still selected, so no float value is caught.
        if (read_done) begin
            rsp_rdata <= dq_sync_reg;
        end
    end

    assign dq_out = wdata_reg;
endmodule
`default_nettype wire

// File: verif/sram_host_checker.sv
/* Pin timing assertions for the memory host controller.
   Bound to sram_host from the bench; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module sram_host_checker #(parameter int ADDR_W = 13) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic retain_safe,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic select_n,
    input wire logic select_active_high,
    input wire logic drive_en_n,
    input wire logic write_n,
    input wire logic dq_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_RD_STROBE: assert property (!drive_en_n |-> write_n)
        else $error("strobe low in read");
    AST_ADDR_FIRST: assert property ($fell(select_n) |-> $stable(mem_addr))
        else $error("address late");
    AST_ADDR_HOLD: assert property (!write_n && !select_n |=> $stable(mem_addr))
        else $error("address moved in write");
    AST_WR_PULSE: assert property ($fell(write_n) |-> !write_n [*4])
        else $error("write pulse short");
    AST_NO_FIGHT: assert property (dq_oe |-> drive_en_n && !$past(write_n))
        else $error("data driven too early");
    AST_RET_DESEL: assert property (retain_safe |-> select_n && !select_active_high)
        else $error("selected in retention");
    AST_DESEL_FIRST: assert property ($rose(retain_safe) |-> $past(select_n))
        else $error("deselect late");
    AST_RECOVER: assert property ($fell(retain_safe) |-> (select_n && !req_ready) [*2])
        else $error("recovery short");
endmodule
`default_nettype wire

// File: verif/sram_mem_model.sv
/* Behavioural 8K x 8 static memory on the controller's pins.
   Resolves the split data bus itself; the clock paces the float pattern and writes. */
`timescale 1ns/1ns
`default_nettype none
module sram_mem_model (
    input wire logic ref_clk,
    input wire logic [12:0] mem_addr,
    input wire logic select_n,
    input wire logic select_active_high,
    input wire logic drive_en_n,
    input wire logic write_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    output logic [7:0] dq_in
);
    logic [7:0] mem [8192];
    logic [7:0] last = 8'h00;
    wire sel = !select_n && select_active_high;
    wire rd = sel && !drive_en_n && write_n;
    // A floating bus flips every cycle so stale data can never pass as a read.
    assign dq_in = dq_oe ? dq_out : rd ? mem[mem_addr] : ~last;
    initial for (int i = 0; i < 8192; i++) mem[i] <= i[7:0] ^ 8'h5a;
    always @(posedge ref_clk) begin
        last <= dq_in;
        if (sel && !write_n && dq_oe) mem[mem_addr] <= dq_out;
    end
endmodule
`default_nettype wire

// File: verif/sram_host_tb.sv
/* Self-checking bench for sram_host against the memory model.
   Assumes a 10 MHz clock; the checker is bound at the foot. */
`timescale 1ns/1ns
`default_nettype none
module sram_host_tb;
    logic ref_clk = 0, rst = 1, req_valid = 0, req_write = 0, retain_req = 0;
    logic [12:0] req_addr = 13'h0000, mem_addr;
    logic [7:0] req_wdata = 8'h00, rsp_rdata, dq_in, dq_out;
    logic req_ready, rsp_valid, retain_safe, select_n, select_active_high;
    logic drive_en_n, write_n, dq_oe;
    int fails = 0, cmp_count = 0, n;
    localparam logic [21:0] ROWS [7] = '{{1'b1, 13'h0000, 8'ha5}, {1'b1, 13'h1fff, 8'h3c},
        {1'b0, 13'h0000, 8'ha5}, {1'b0, 13'h1fff, 8'h3c}, {1'b0, 13'h0123, 8'h79},
        {1'b1, 13'h0123, 8'h00}, {1'b0, 13'h0123, 8'h00}};
    sram_host i_sram_host (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .retain_req(retain_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .retain_safe(retain_safe), .mem_addr(mem_addr),
        .select_n(select_n), .select_active_high(select_active_high),
        .drive_en_n(drive_en_n), .write_n(write_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe));
    sram_mem_model i_sram_mem_model (.ref_clk(ref_clk), .mem_addr(mem_addr),
        .select_n(select_n), .select_active_high(select_active_high),
        .drive_en_n(drive_en_n), .write_n(write_n), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge ref_clk);
        #10;
        n++;
        if (n > 50) begin
            chk("wait", 16'h0000, 16'h0001);
            print_verdict();
        end
    endtask
    task automatic xfer(input logic [21:0] r);
        n = 0;
        while (req_ready !== 1'b1) step();
        {req_write, req_addr, req_wdata} = r;
        req_valid = 1'b1;
        n = 0;
        step();
        req_valid = 1'b0;
        n = 0;
        if (!r[21]) begin
            while (rsp_valid !== 1'b1) step();
            chk("read latency", 16'h0004, 16'(n));
            chk("read data", {8'h00, r[7:0]}, {8'h00, rsp_rdata});
            step();
            chk("read end", 16'h0003, {13'h0000, rsp_valid, select_n, drive_en_n});
        end
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        #10;
        chk("reset selects", 16'h0002, {14'h0000, select_n, select_active_high});
        chk("reset strobe", 16'h0002, {14'h0000, write_n, dq_oe});
        rst = 1'b0;
        $display("test reset done");
        for (int i = 0; i < 7; i++) xfer(ROWS[i]);
        $display("test rows done");
        retain_req = 1'b1;
        n = 0;
        while (retain_safe !== 1'b1) step();
        chk("retain selects", 16'h0002, {14'h0000, select_n, select_active_high});
        retain_req = 1'b0;
        n = 0;
        while (retain_safe !== 1'b0) step();
        chk("recovery ready", 16'h0000, {15'h0000, req_ready});
        xfer({1'b0, 13'h1fff, 8'h3c});
        $display("test retention done");
        xfer({1'b1, 13'h0040, 8'hc3});
        step();
        rst = 1'b1;
        step();
        chk("cut selects", 16'h0002, {14'h0000, select_n, select_active_high});
        chk("cut strobes", 16'h000a, {12'h000, write_n, dq_oe, drive_en_n, req_ready});
        rst = 1'b0;
        xfer({1'b0, 13'h0040, 8'h1a});
        $display("test cut write done");
        print_verdict();
    end
endmodule
bind sram_host sram_host_checker #(.ADDR_W(ADDR_W)) i_sram_host_checker (.ref_clk(ref_clk),
    .rst(rst), .req_ready(req_ready), .retain_safe(retain_safe), .mem_addr(mem_addr),
    .select_n(select_n), .select_active_high(select_active_high),
    .drive_en_n(drive_en_n), .write_n(write_n), .dq_oe(dq_oe));
`default_nettype wire
